// >>> hw/gp_timer_consts.svh
// constants for the two-block timer: offsets, fields, reset values
// Notes on behaviour
// R1 - Each block walks its timers and the capture/reload register one state at a time.
// R2 - A whole pass of a block's sequence fits in one basic clock cycle.
// R3 - Block two has 4 states, 2 when its prescaler is 01, core counter before secondary.
// R4 - Block one has 8 states, 4 when its prescaler is 01.
// R5 - Block one order is core, first aux (non-capture), second aux, first aux capture.
// R6 - Timer mode 001 makes block two counters count input edges, direction from their pins.
// R7 - Software keeps block two prescaler at 0X while either counter is in counter mode.
// R8 - The secondary counter can count core counter wraps in every prescaler setting.
// R9 - Either aux timer can reload the core timer on its overflow or underflow.
// R10 - Prescaler 01 with input select 000 gives the core timer its fastest count.
// R11 - A reload from the second aux timer adds no basic cycle of delay.
// R12 - Each core timer wrap raises an interrupt and flips the toggle output.
// R13 - A reload from the first aux timer adds no delay, and a read then shows the reload value.
// R14 - Reset clears all timers, prescaler fields and state machines.
`ifndef GP_TIMER_CONSTS_SVH
`define GP_TIMER_CONSTS_SVH
`define OFS_CTRL1 4'h0
`define OFS_CORE 4'h1
`define OFS_AUX1 4'h2
`define OFS_AUX2 4'h3
`define OFS_CAPTURE_RELOAD_REGISTER 4'h4
`define OFS_CTRL2 4'h5
`define OFS_CORE2 4'h6
`define OFS_SEC2 4'h7
`define OFS_STAT 4'h8
`define OFS_MASK 4'h9
`define OFS_TOGGLE 4'ha
`define C1_BPS 1:0
`define C1_ISEL 4:2
`define C1_DOWN 5
`define C1_RUN 6
`define C1_RL1 7
`define C1_RL2 8
`define C1_AUX1_RUN 9
`define C1_AUX2_RUN 10
`define C1_CAP_EN 11
`define C2_BPS 1:0
`define C2_CORE_MODE 4:2
`define C2_SEC_MODE 7:5
`define C2_CORE_RUN 8
`define C2_SEC_RUN 9
`define C2_CHAIN 10
`define C2_DOWN 11
`define ST_CORE 0
`define ST_AUX1 1
`define ST_AUX2 2
`define ST_CAP 3
`define ST_CORE2 4
`define ST_SEC2 5
`define BPS_FAST 2'h1
`define MODE_TIMER 3'h0
`define MODE_COUNTER 3'h1
`define RST_REG 16'h0000
`endif

// >>> hw/gp_timer_pkg.sv
// types shared by the timer blocks
package gp_timer_pkg;
  typedef enum logic [2:0] {S1_CORE, S1_AUX1, S1_AUX2, S1_CAP, S1_PAD0, S1_PAD1, S1_PAD2, S1_PAD3} blk1_state_t;
  typedef enum logic [1:0] {S2_CORE, S2_SEC, S2_PAD0, S2_PAD1} blk2_state_t;
endpackage

// >>> hw/state_step_gen.sv
// state step pulse from a block prescaler
`timescale 1ns/1ps
`default_nettype none
module state_step_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] presc_i,
  output logic step_o
);
  logic [1:0] div_q, div_d;
  logic [1:0] lim;
  always_comb begin
    lim = (presc_i == 2'h3) ? 2'h3 : (presc_i == 2'h2) ? 2'h1 : 2'h0;
    div_d = (div_q >= lim) ? 2'h0 : div_q + 2'h1;
    step_o = (div_q >= lim);
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= 2'h0;
    end else if (ce_i) begin
      div_q <= div_d;
    end
  end
endmodule // state_step_gen
`default_nettype wire

// >>> hw/edge_catch.sv
// rising edge catchers holding a pending flag until taken
`timescale 1ns/1ps
`default_nettype none
module edge_catch #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [N-1:0] sig_i,
  input wire logic [N-1:0] take_i,
  output logic [N-1:0] pend_o
);
  logic [N-1:0] prev_q, prev_d, pend_q, pend_d;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // a new edge in the take cycle stays pending
      always_comb begin
        prev_d[g] = sig_i[g];
        pend_d[g] = (pend_q[g] & ~take_i[g]) | (sig_i[g] & ~prev_q[g]);
      end
    end
  endgenerate
  assign pend_o = pend_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_q <= '0;
      pend_q <= '0;
    end else if (ce_i) begin
      prev_q <= prev_d;
      pend_q <= pend_d;
    end
  end
endmodule // edge_catch
`default_nettype wire

// >>> hw/gp_timer_top.sv
// two sequenced timer blocks behind a classic wishbone slave
`timescale 1ns/1ps
`include "gp_timer_consts.svh"
`default_nettype none
module gp_timer_top
  import gp_timer_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [1:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_input_i,
  input wire logic secondary_count_input_i,
  input wire logic core2_count_input_i,
  input wire logic secondary_dir_input_i,
  input wire logic core2_dir_input_i,
  output logic core_toggle_output_o,
  output logic irq_o
);
  logic ack_q, ack_d, acc, wr;
  logic [3:0] idx;
  logic [W-1:0] wm, wd;
  logic [31:0] rdat_q, rdat_d;
  logic [W-1:0] ctrl1_q, ctrl1_d, core_q, core_d, aux1_q, aux1_d, aux2_q, aux2_d, capture_reload_register_q, capture_reload_register_d;
  logic [W-1:0] ctrl2_q, ctrl2_d, core2_q, core2_d, sec_q, sec_d;
  logic [5:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic tog_q, tog_d, irq_q, irq_d;
  logic [7:0] pre1_q, pre1_d;
  logic tick1_q, tick1_d, wrap2_q, wrap2_d;
  blk1_state_t st1_q, st1_d;
  blk2_state_t st2_q, st2_d;
  logic step1, step2, wrap1;
  logic [3:0] ev1;
  logic [1:0] ev2, take2;
  logic take1;
  logic [2:0] pend, take;

  function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] m, input logic [W-1:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  // a full pass of either block is one basic clock cycle of its timers [R2]
  state_step_gen u_step1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .presc_i(ctrl1_q[`C1_BPS]),
    .step_o(step1)
  );
  state_step_gen u_step2 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .presc_i(ctrl2_q[`C2_BPS]),
    .step_o(step2)
  );
  // edges are held until their counter's state comes round; a second edge within one pass merges with the first
  edge_catch #(.N(3)) u_edges (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .sig_i({capture_input_i, secondary_count_input_i, core2_count_input_i}),
    .take_i(take),
    .pend_o(pend)
  );
  // each block drives only its own slice, one process per slice
  assign ev = {ev2, ev1};
  assign take = {take1, take2};

  // bus slave: answer one cycle after the request, writes commit at that same edge
  always_comb begin
    acc = wb_cyc_i & wb_stb_i & ~ack_q;
    wr = acc & wb_we_i;
    idx = wb_adr_i[5:2];
    wm = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wd = wb_dat_i[W-1:0];
    ack_d = acc;
    rdat_d = 32'h0;
    case (idx)
      `OFS_CTRL1: rdat_d[W-1:0] = ctrl1_q;
      `OFS_CORE: rdat_d[W-1:0] = core_q;
      `OFS_AUX1: rdat_d[W-1:0] = aux1_q;
      `OFS_AUX2: rdat_d[W-1:0] = aux2_q;
      `OFS_CAPTURE_RELOAD_REGISTER: rdat_d[W-1:0] = capture_reload_register_q;
      `OFS_CTRL2: rdat_d[W-1:0] = ctrl2_q;
      `OFS_CORE2: rdat_d[W-1:0] = core2_q;
      `OFS_SEC2: rdat_d[W-1:0] = sec_q;
      `OFS_STAT: rdat_d[5:0] = stat_q;
      `OFS_MASK: rdat_d[5:0] = mask_q;
      `OFS_TOGGLE: rdat_d[0] = tog_q;
      default: rdat_d = 32'h0;
    endcase
  end

  // block one: core, aux1, aux2, capture, then pads unless prescaler is fast
  always_comb begin
    st1_d = st1_q;
    pre1_d = pre1_q;
    tick1_d = tick1_q;
    core_d = core_q;
    aux1_d = aux1_q;
    aux2_d = aux2_q;
    capture_reload_register_d = capture_reload_register_q;
    tog_d = tog_q;
    wrap1 = 1'b0;
    ev1 = 4'h0;
    take1 = 1'b0;
    if (step1) begin
      case (st1_q) // [R1] [R5]
        S1_CORE: begin
          st1_d = S1_AUX1;
          tick1_d = 1'b0;
          if (ctrl1_q[`C1_RUN]) begin
            // select 000 counts every basic cycle [R10]
            if (pre1_q >= 8'((9'h1 << ctrl1_q[`C1_ISEL]) - 9'h1)) begin
              pre1_d = 8'h0;
              tick1_d = 1'b1;
              wrap1 = ctrl1_q[`C1_DOWN] ? (core_q == '0) : (core_q == '1);
              core_d = ctrl1_q[`C1_DOWN] ? core_q - 1'b1 : core_q + 1'b1;
              if (wrap1) begin
                // reload lands in the wrap step itself, no lag [R9] [R11] [R13]
                if (ctrl1_q[`C1_RL2]) begin
                  core_d = aux2_q;
                end else if (ctrl1_q[`C1_RL1]) begin
                  core_d = aux1_q;
                end
                ev1[0] = 1'b1; // [R12]
                tog_d = ~tog_q; // [R12]
              end
            end else begin
              pre1_d = pre1_q + 8'h1;
            end
          end
        end
        S1_AUX1: begin
          st1_d = S1_AUX2;
          if (ctrl1_q[`C1_AUX1_RUN] && tick1_q) begin
            aux1_d = aux1_q + 1'b1;
            ev1[1] = (aux1_q == '1);
          end
        end
        S1_AUX2: begin
          st1_d = S1_CAP;
          if (ctrl1_q[`C1_AUX2_RUN] && tick1_q) begin
            aux2_d = aux2_q + 1'b1;
            ev1[2] = (aux2_q == '1);
          end
        end
        S1_CAP: begin
          st1_d = (ctrl1_q[`C1_BPS] == `BPS_FAST) ? S1_CORE : S1_PAD0; // [R4]
          take1 = pend[2];
          if (pend[2] && ctrl1_q[`C1_CAP_EN]) begin
            capture_reload_register_d = aux1_q;
            ev1[3] = 1'b1;
          end
        end
        S1_PAD0: st1_d = S1_PAD1;
        S1_PAD1: st1_d = S1_PAD2;
        S1_PAD2: st1_d = S1_PAD3;
        S1_PAD3: st1_d = S1_CORE;
        default: st1_d = S1_CORE;
      endcase
    end
    if (wr && idx == `OFS_CORE) core_d = merge(core_q, wm, wd);
    if (wr && idx == `OFS_AUX1) aux1_d = merge(aux1_q, wm, wd);
    if (wr && idx == `OFS_AUX2) aux2_d = merge(aux2_q, wm, wd);
    if (wr && idx == `OFS_CAPTURE_RELOAD_REGISTER) capture_reload_register_d = merge(capture_reload_register_q, wm, wd);
    ctrl1_d = (wr && idx == `OFS_CTRL1) ? merge(ctrl1_q, wm, wd) : ctrl1_q;
  end

  // block two: core counter then secondary, pads unless prescaler is fast
  always_comb begin
    st2_d = st2_q;
    core2_d = core2_q;
    sec_d = sec_q;
    wrap2_d = wrap2_q;
    ev2 = 2'h0;
    take2 = 2'h0;
    if (step2) begin
      case (st2_q) // [R1] [R3]
        S2_CORE: begin
          st2_d = S2_SEC;
          wrap2_d = 1'b0;
          take2[0] = pend[0];
          if (ctrl2_q[`C2_CORE_RUN]) begin
            if (ctrl2_q[`C2_CORE_MODE] == `MODE_COUNTER) begin
              if (pend[0]) begin // [R6]
                core2_d = core2_dir_input_i ? core2_q - 1'b1 : core2_q + 1'b1;
                wrap2_d = core2_dir_input_i ? (core2_q == '0) : (core2_q == '1);
              end
            end else begin
              core2_d = ctrl2_q[`C2_DOWN] ? core2_q - 1'b1 : core2_q + 1'b1;
              wrap2_d = ctrl2_q[`C2_DOWN] ? (core2_q == '0) : (core2_q == '1);
            end
            ev2[0] = wrap2_d;
          end
        end
        S2_SEC: begin
          st2_d = (ctrl2_q[`C2_BPS] == `BPS_FAST) ? S2_CORE : S2_PAD0; // [R3]
          take2[1] = pend[1];
          if (ctrl2_q[`C2_SEC_RUN]) begin
            // chained input is an internal flag, not a pin edge, so any prescaler works [R8]
            if (ctrl2_q[`C2_CHAIN]) begin
              if (wrap2_q) begin
                sec_d = sec_q + 1'b1;
                ev2[1] = (sec_q == '1);
              end
            end else if (ctrl2_q[`C2_SEC_MODE] == `MODE_COUNTER) begin
              if (pend[1]) begin // [R6]
                sec_d = secondary_dir_input_i ? sec_q - 1'b1 : sec_q + 1'b1;
                ev2[1] = secondary_dir_input_i ? (sec_q == '0) : (sec_q == '1);
              end
            end else begin
              sec_d = sec_q + 1'b1;
              ev2[1] = (sec_q == '1);
            end
          end
        end
        S2_PAD0: st2_d = S2_PAD1;
        S2_PAD1: st2_d = S2_CORE;
        default: st2_d = S2_CORE;
      endcase
    end
    if (wr && idx == `OFS_CORE2) core2_d = merge(core2_q, wm, wd);
    if (wr && idx == `OFS_SEC2) sec_d = merge(sec_q, wm, wd);
    ctrl2_d = (wr && idx == `OFS_CTRL2) ? merge(ctrl2_q, wm, wd) : ctrl2_q;
  end

  // sticky status, write one to clear, a same-cycle event wins
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr && idx == `OFS_STAT && wb_sel_i[0]) stat_d = stat_q & ~wb_dat_i[5:0];
    if (wr && idx == `OFS_MASK && wb_sel_i[0]) mask_d = wb_dat_i[5:0];
    stat_d = stat_d | ev;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin // [R14]
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
      ctrl1_q <= `RST_REG;
      ctrl2_q <= `RST_REG;
      core_q <= `RST_REG;
      aux1_q <= `RST_REG;
      aux2_q <= `RST_REG;
      capture_reload_register_q <= `RST_REG;
      core2_q <= `RST_REG;
      sec_q <= `RST_REG;
      stat_q <= 6'h0;
      mask_q <= 6'h0;
      tog_q <= 1'b0;
      irq_q <= 1'b0;
      pre1_q <= 8'h0;
      tick1_q <= 1'b0;
      wrap2_q <= 1'b0;
      st1_q <= S1_CORE;
      st2_q <= S2_CORE;
    end else if (ce_i) begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      core_q <= core_d;
      aux1_q <= aux1_d;
      aux2_q <= aux2_d;
      capture_reload_register_q <= capture_reload_register_d;
      core2_q <= core2_d;
      sec_q <= sec_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      tog_q <= tog_d;
      irq_q <= irq_d;
      pre1_q <= pre1_d;
      tick1_q <= tick1_d;
      wrap2_q <= wrap2_d;
      st1_q <= st1_d;
      st2_q <= st2_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign core_toggle_output_o = tog_q;
  assign irq_o = irq_q;

  // checks
  logic wrap_go, cwr;
  assign wrap_go = ce_i && step1 && wrap1;
  assign cwr = wr && idx == `OFS_CORE;

  property p_reload2;
    @(posedge clk_i) disable iff (!rst_n_i) wrap_go && ctrl1_q[`C1_RL2] && !cwr |=> core_q == $past(aux2_q);
  endproperty
  a_reload2: assert property (p_reload2) else $error("core not reloaded from aux2"); // [R11]
  property p_reload1;
    @(posedge clk_i) disable iff (!rst_n_i)
      wrap_go && !ctrl1_q[`C1_RL2] && ctrl1_q[`C1_RL1] && !cwr |=> core_q == $past(aux1_q);
  endproperty
  a_reload1: assert property (p_reload1) else $error("core not reloaded from aux1"); // [R13]
  property p_wrap_irq;
    @(posedge clk_i) disable iff (!rst_n_i) wrap_go |=> stat_q[0] && tog_q != $past(tog_q);
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap gave no flag or toggle"); // [R12]
  property p_order1;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && step1 && (st1_q == S1_CORE || st1_q == S1_AUX1 || st1_q == S1_AUX2)
      |=> st1_q == (($past(st1_q) == S1_CORE) ? S1_AUX1 : ($past(st1_q) == S1_AUX1) ? S1_AUX2 : S1_CAP);
  endproperty
  a_order1: assert property (p_order1) else $error("block one order broken"); // [R5]
  property p_short1;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && step1 && st1_q == S1_CAP && ctrl1_q[`C1_BPS] == `BPS_FAST |=> st1_q == S1_CORE;
  endproperty
  a_short1: assert property (p_short1) else $error("block one not shortened"); // [R4]
  property p_long1;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && step1 && st1_q == S1_CAP && ctrl1_q[`C1_BPS] != `BPS_FAST |=> st1_q == S1_PAD0;
  endproperty
  a_long1: assert property (p_long1) else $error("block one pads skipped"); // [R4]
  property p_order2;
    @(posedge clk_i) disable iff (!rst_n_i) ce_i && step2 && st2_q == S2_CORE |=> st2_q == S2_SEC;
  endproperty
  a_order2: assert property (p_order2) else $error("block two order broken"); // [R3]
  property p_cnt2;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && step2 && st2_q == S2_CORE && ctrl2_q[`C2_CORE_RUN] && ctrl2_q[`C2_CORE_MODE] == `MODE_COUNTER
      && pend[0] && !core2_dir_input_i && !(wr && idx == `OFS_CORE2) |=> core2_q == $past(core2_q) + 1'b1;
  endproperty
  a_cnt2: assert property (p_cnt2) else $error("counter mode edge not counted"); // [R6]
  property p_chain;
    @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && step2 && st2_q == S2_SEC && ctrl2_q[`C2_SEC_RUN] && ctrl2_q[`C2_CHAIN] && wrap2_q
      && !(wr && idx == `OFS_SEC2) |=> sec_q == $past(sec_q) + 1'b1;
  endproperty
  a_chain: assert property (p_chain) else $error("chained wrap not counted"); // [R8]
  c_reload: cover property (@(posedge clk_i) disable iff (!rst_n_i) wrap_go && ctrl1_q[`C1_RL2]);
  c_chain: cover property (@(posedge clk_i) disable iff (!rst_n_i) ev[5] && ctrl2_q[`C2_CHAIN]);
  c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) irq_o);
endmodule // gp_timer_top
`default_nettype wire

// >>> testbench/tb_gp_timer_top.sv
// self-checking bench for the two sequenced timer blocks
`timescale 1ns/1ps
`default_nettype none
module tb_gp_timer_top;
  logic clk_i;
  logic rst_n_i;
  logic cyc;
  logic stb;
  logic we;
  logic [5:0] adr;
  logic [1:0] sel;
  logic [31:0] wdat;
  logic [31:0] dat_o;
  logic ack;
  logic cap_in;
  logic sec_in;
  logic c2_in;
  logic sec_dir;
  logic c2_dir;
  logic tog;
  logic irq;
  logic [31:0] d;
  logic [31:0] d2;
  logic ce;
  int fail_count;
  int n_checks;
  int cyc_cnt;
  int per;
  int k;
  int pc[4] = '{8, 4, 16, 32};

  gp_timer_top u_gp_timer_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .capture_input_i(cap_in), .secondary_count_input_i(sec_in), .core2_count_input_i(c2_in),
    .secondary_dir_input_i(sec_dir), .core2_dir_input_i(c2_dir),
    .core_toggle_output_o(tog), .irq_o(irq)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb_wr(input logic [3:0] idx, input logic [15:0] v, input logic [1:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= {idx, 2'h0};
    sel <= s;
    wdat <= {16'h0000, v};
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wb_rd(input logic [3:0] idx, output logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b0;
    adr <= {idx, 2'h0};
    sel <= 2'h3;
    do @(posedge clk_i); while (ack !== 1'b1);
    v = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    wb_rd(idx, v);
    chk(v, exp);
  endtask

  // cycles until the toggle pin next changes, bounded
  task automatic tog_wait(output int n);
    logic t;
    t = tog;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tog === t && n < 4000);
  endtask

  // third interval is a full reload period; the first starts mid-count
  task automatic meas(input logic [3:0] rl, input logic [15:0] ctl, input logic [15:0] v, output int p);
    wb_wr(4'h0, 16'h0000, 2'h3);
    wb_wr(rl, v, 2'h3);
    wb_wr(4'h1, v, 2'h3);
    wb_wr(4'h0, ctl, 2'h3);
    tog_wait(p);
    tog_wait(p);
    tog_wait(p);
  endtask

  // 0 core2 input, 1 secondary input, 2 capture input
  task automatic pulse(input int w);
    @(posedge clk_i);
    if (w == 0) begin
      c2_in <= 1'b1;
    end else if (w == 1) begin
      sec_in <= 1'b1;
    end else begin
      cap_in <= 1'b1;
    end
    repeat (20) @(posedge clk_i);
    c2_in <= 1'b0;
    sec_in <= 1'b0;
    cap_in <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // bench ceiling well above the longest reload periods
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 2'h0;
    wdat = 32'h00000000;
    cap_in = 1'b0;
    sec_in = 1'b0;
    c2_in = 1'b0;
    sec_dir = 1'b0;
    c2_dir = 1'b0;
    fail_count = 0;
    n_checks = 0;
    cyc_cnt = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wb_wr(4'hb, 16'hffff, 2'h3);
    for (int i = 0; i < 12; i++) rchk(4'(i), 32'h0);
    wb_wr(4'h3, 16'h1234, 2'h3);
    wb_wr(4'h3, 16'habcd, 2'h1);
    rchk(4'h3, 32'h12cd);
    $display("test reset_and_bus done");

    wb_wr(4'h0, 16'h0800, 2'h3);
    wb_wr(4'h2, 16'h5a5a, 2'h3);
    pulse(2);
    rchk(4'h4, 32'h5a5a);
    rchk(4'h8, 32'h0008);
    wb_wr(4'h8, 16'h003f, 2'h1);
    $display("test capture done");

    // wrap period = 16 counts times the pass length of each prescaler
    for (int p = 0; p < 4; p++) begin
      meas(4'h3, 16'h0140 | 16'(p), 16'hfff0, per);
      chk(32'(per), 32'(16 * pc[p]));
    end
    meas(4'h2, 16'h00c1, 16'hfff0, per);
    chk(32'(per), 32'd64);
    meas(4'h3, 16'h0161, 16'h0010, per);
    chk(32'(per), 32'd68);
    $display("test reload_period done");

    wb_wr(4'h0, 16'h0000, 2'h3);
    rchk(4'h8, 32'h0001);
    wb_wr(4'h9, 16'h0000, 2'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wb_wr(4'h9, 16'h0001, 2'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wb_wr(4'h8, 16'h0001, 2'h1);
    rchk(4'h8, 32'h0000);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");

    // prescaler kept at 0X while counters run in counter mode
    wb_wr(4'h5, 16'h0325, 2'h3);
    repeat (3) pulse(0);
    rchk(4'h6, 32'h3);
    c2_dir <= 1'b1;
    pulse(0);
    rchk(4'h6, 32'h2);
    c2_dir <= 1'b0;
    repeat (2) pulse(1);
    sec_dir <= 1'b1;
    pulse(1);
    rchk(4'h7, 32'h1);
    sec_dir <= 1'b0;
    wb_wr(4'h6, 16'hffff, 2'h3);
    wb_wr(4'h5, 16'h0725, 2'h3);
    pulse(0);
    rchk(4'h6, 32'h0);
    rchk(4'h7, 32'h2);
    $display("test counter_mode done");

    wb_wr(4'h5, 16'h0000, 2'h3);
    wb_wr(4'h7, 16'h0000, 2'h3);
    for (int p = 0; p < 4; p++) begin
      wb_wr(4'h6, 16'hfffe, 2'h3);
      wb_wr(4'h8, 16'h003f, 2'h1);
      wb_wr(4'h5, 16'h0700 | 16'(p), 2'h3);
      k = 0;
      do begin
        wb_rd(4'h8, d);
        k++;
      end while (d[4] !== 1'b1 && k < 300);
      wb_wr(4'h5, 16'h0000, 2'h3);
      rchk(4'h7, 32'(p + 1));
    end
    $display("test chain done");

    // a frozen block may move only on the few live edges around the two reads
    wb_wr(4'h1, 16'h0000, 2'h3);
    wb_wr(4'h0, 16'h0041, 2'h3);
    repeat (40) @(posedge clk_i);
    wb_rd(4'h1, d);
    ce <= 1'b0;
    repeat (200) @(posedge clk_i);
    ce <= 1'b1;
    wb_rd(4'h1, d2);
    chk({31'h0, d != 32'h0}, 32'h1);
    chk({31'h0, (d2 - d) <= 32'h1}, 32'h1);
    $display("test freeze done");

    wb_wr(4'h9, 16'h003f, 2'h1);
    wb_wr(4'h0, 16'h0141, 2'h3);
    repeat (100) @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk({31'h0, tog}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 12; i++) rchk(4'(i), 32'h0);
    $display("test mid_run_reset done");
    stop_test();
  end
endmodule // tb_gp_timer_top
`default_nettype wire
